// ==== src/dcs_pkg.sv ====
/*
  Constants for the debugger control and status block: control and status
  bit positions, host command bytes, serial bit timing and link states.
  Assumes a single 50 MHz core clock and a host at a fixed bit rate.
*/
package dcs_pkg;

  // ---------------------------------------------------------------
  // Control register bit positions
  // ---------------------------------------------------------------
  localparam int CTL_DEBUG_MODE_BIT = 7;
  localparam int CTL_BREAK_EN_BIT = 6;
  localparam int CTL_ACKEN_BIT = 5;
  localparam int CTL_RESET_BIT = 0;

  // ---------------------------------------------------------------
  // Status register bit positions, status and control reset values
  // ---------------------------------------------------------------
  localparam int STAT_DEBUG_BIT = 7;
  localparam int STAT_HALT_BIT = 6;
  localparam int STAT_PROTECT_BIT = 5;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Host command bytes and acknowledge character
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RD_REV = 8'h00;
  localparam logic [7:0] CMD_RD_STAT = 8'h02;
  localparam logic [7:0] CMD_WR_CTL = 8'h04;
  localparam logic [7:0] CMD_RD_CTL = 8'h05;
  localparam logic [7:0] CMD_WR_PC = 8'h06;
  localparam logic [7:0] CMD_RD_PC = 8'h07;
  localparam logic [7:0] CMD_RD_REG = 8'h09;
  localparam logic [7:0] ACK_CHAR = 8'hFF;

  // ---------------------------------------------------------------
  // Serial timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int BAUD_RATE = 115_200;
  localparam logic [15:0] BIT_CYCLES = 16'(CLK_FREQ_HZ / BAUD_RATE);
  localparam logic [15:0] HALF_CYCLES = 16'(CLK_FREQ_HZ / BAUD_RATE / 2);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ---------------------------------------------------------------
  // Link states, Gray along receive path; transmit entry and exit flip two bits
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_RX_START = 3'b001,
    LK_RX_DATA = 3'b011,
    LK_RX_STOP = 3'b010,
    LK_TX_START = 3'b110,
    LK_TX_DATA = 3'b111,
    LK_TX_STOP = 3'b101
  } dcs_link_t;

endpackage : dcs_pkg

// ==== src/dcs_debugger_control_status.sv ====
/*
  Debugger control and status logic: one-wire half-duplex serial link to
  the host, control bits, status byte, break and watchpoint handling.
  Assumes CPU-side inputs are on CORE_CLK and the line has a pull-up.
*/
`timescale 1ns/1ps
module dcs_debugger_control_status (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Debug line, open drain
  input wire logic DEBUG_LINE_IN,
  output logic DEBUG_LINE_OUT,
  output logic DEBUG_LINE_OE,
  // CPU events and state
  input wire logic BREAK_DECODE,
  input wire logic WATCH_HIT,
  input wire logic HALT_MODE,
  input wire logic READ_PROTECT,
  input wire logic RESET_DONE,
  // CPU controls
  output logic BREAK_AS_NOP,
  output logic DEBUG_MODE,
  output logic DEVICE_RESET_REQ,
  // Forwarded host commands
  output logic CMD_VALID,
  output logic [7:0] CMD_BYTE
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  dcs_pkg::dcs_link_t state_q;
  logic sync1_q, sync2_q;
  logic [15:0] timer_q;
  logic [2:0] bitn_q;
  logic [7:0] shreg_q;
  logic [7:0] rx_byte_q;
  logic rx_valid_q;
  logic debug_mode_q, break_en_q, acken_q, rst_q;
  logic wait_data_q;
  logic resp_pend_q, ack_pend_q;
  logic [7:0] resp_q;
  logic cmd_valid_q;
  logic [7:0] cmd_byte_q;

  // ---------------------------------------------------------------
  // Command gating
  // ---------------------------------------------------------------
  function automatic logic cmd_allowed(input logic [7:0] cmd, input logic in_debug, input logic prot);
    logic basic;
    logic locked;
    basic = (cmd == dcs_pkg::CMD_RD_REV) || (cmd == dcs_pkg::CMD_RD_STAT) ||
            (cmd == dcs_pkg::CMD_WR_CTL) || (cmd == dcs_pkg::CMD_RD_CTL);
    locked = (cmd == dcs_pkg::CMD_WR_PC) || (cmd == dcs_pkg::CMD_RD_PC) ||
             (cmd == dcs_pkg::CMD_RD_REG);
    if (!in_debug) begin
      return basic;
    end
    return !(prot && locked);
  endfunction : cmd_allowed

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire line = sync2_q;
  wire tick = (timer_q == 16'h0000);
  wire tx_req = resp_pend_q | ack_pend_q;
  wire [7:0] tx_byte = resp_pend_q ? resp_q : dcs_pkg::ACK_CHAR;
  wire tx_take = (state_q == dcs_pkg::LK_IDLE) && tx_req;
  wire break_hit = BREAK_DECODE & break_en_q;
  wire bp_event = break_hit | WATCH_HIT;
  wire [7:0] status_byte = {debug_mode_q, HALT_MODE, READ_PROTECT, 5'h00};
  wire [7:0] ctl_byte = {debug_mode_q, break_en_q, acken_q, 4'h0, rst_q};
  wire is_data = rx_valid_q & wait_data_q;
  wire is_cmd = rx_valid_q & ~wait_data_q;
  wire allowed = cmd_allowed(rx_byte_q, debug_mode_q, READ_PROTECT);
  wire ctl_wr = is_data;
  // Protected parts may not leave debug mode through a control write
  wire wr_mode_ok = !(READ_PROTECT && !rx_byte_q[dcs_pkg::CTL_DEBUG_MODE_BIT]);

  assign BREAK_AS_NOP = BREAK_DECODE & ~break_en_q;
  assign DEBUG_MODE = debug_mode_q;
  assign DEVICE_RESET_REQ = rst_q;
  assign CMD_VALID = cmd_valid_q;
  assign CMD_BYTE = cmd_byte_q;
  // Line is only ever pulled low; the pull-up gives the high level
  assign DEBUG_LINE_OUT = 1'b0;
  assign DEBUG_LINE_OE = (state_q == dcs_pkg::LK_TX_START) ||
                  ((state_q == dcs_pkg::LK_TX_DATA) && !shreg_q[0]);

  // ---------------------------------------------------------------
  // Line synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= DEBUG_LINE_IN;
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // Serial link
  // ---------------------------------------------------------------
  // One state machine owns the line, so send and receive never overlap
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= dcs_pkg::LK_IDLE;
      timer_q <= 16'h0000;
      bitn_q <= 3'h0;
      shreg_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      timer_q <= tick ? dcs_pkg::BIT_CYCLES - 16'h0001 : timer_q - 16'h0001;
      unique case (state_q)
        dcs_pkg::LK_IDLE: begin
          bitn_q <= 3'h0;
          if (tx_req) begin
            state_q <= dcs_pkg::LK_TX_START;
            shreg_q <= tx_byte;
            timer_q <= dcs_pkg::BIT_CYCLES - 16'h0001;
          end else if (!line) begin
            state_q <= dcs_pkg::LK_RX_START;
            timer_q <= dcs_pkg::HALF_CYCLES - 16'h0001;
          end
        end
        dcs_pkg::LK_RX_START: begin
          if (tick) begin
            state_q <= line ? dcs_pkg::LK_IDLE : dcs_pkg::LK_RX_DATA;
          end
        end
        dcs_pkg::LK_RX_DATA: begin
          if (tick) begin
            shreg_q <= {line, shreg_q[7:1]};
            bitn_q <= bitn_q + 3'h1;
            if (bitn_q == dcs_pkg::LAST_BIT) begin
              state_q <= dcs_pkg::LK_RX_STOP;
            end
          end
        end
        dcs_pkg::LK_RX_STOP: begin
          if (tick) begin
            state_q <= dcs_pkg::LK_IDLE;
            // Framing errors are dropped silently
            rx_valid_q <= line;
            rx_byte_q <= shreg_q;
          end
        end
        dcs_pkg::LK_TX_START: begin
          if (tick) begin
            state_q <= dcs_pkg::LK_TX_DATA;
          end
        end
        dcs_pkg::LK_TX_DATA: begin
          if (tick) begin
            shreg_q <= {1'b1, shreg_q[7:1]};
            bitn_q <= bitn_q + 3'h1;
            if (bitn_q == dcs_pkg::LAST_BIT) begin
              state_q <= dcs_pkg::LK_TX_STOP;
            end
          end
        end
        dcs_pkg::LK_TX_STOP: begin
          if (tick) begin
            state_q <= dcs_pkg::LK_IDLE;
          end
        end
        default: begin
          state_q <= dcs_pkg::LK_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  // ARST_N clears these and RESET_DONE the reset bit; the device reset request leaves them alone
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      debug_mode_q <= dcs_pkg::CTL_RESET[dcs_pkg::CTL_DEBUG_MODE_BIT];
      break_en_q <= dcs_pkg::CTL_RESET[dcs_pkg::CTL_BREAK_EN_BIT];
      acken_q <= dcs_pkg::CTL_RESET[dcs_pkg::CTL_ACKEN_BIT];
      rst_q <= dcs_pkg::CTL_RESET[dcs_pkg::CTL_RESET_BIT];
    end else begin
      if (bp_event) begin
        debug_mode_q <= 1'b1;
      end else if (ctl_wr && wr_mode_ok) begin
        debug_mode_q <= rx_byte_q[dcs_pkg::CTL_DEBUG_MODE_BIT];
      end
      if (ctl_wr) begin
        break_en_q <= rx_byte_q[dcs_pkg::CTL_BREAK_EN_BIT];
        acken_q <= rx_byte_q[dcs_pkg::CTL_ACKEN_BIT];
      end
      // Reserved bits are not stored; host keeps them zero
      if (ctl_wr && rx_byte_q[dcs_pkg::CTL_RESET_BIT]) begin
        rst_q <= 1'b1;
      end else if (RESET_DONE) begin
        rst_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command handling and replies
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_data_q <= 1'b0;
      resp_pend_q <= 1'b0;
      resp_q <= dcs_pkg::STAT_RESET;
      ack_pend_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_byte_q <= 8'h00;
    end else begin
      cmd_valid_q <= 1'b0;
      if (is_data) begin
        wait_data_q <= 1'b0;
      end else if (is_cmd && allowed) begin
        if (rx_byte_q == dcs_pkg::CMD_WR_CTL) begin
          wait_data_q <= 1'b1;
        end else if (rx_byte_q == dcs_pkg::CMD_RD_STAT) begin
          resp_q <= status_byte;
        end else if (rx_byte_q == dcs_pkg::CMD_RD_CTL) begin
          resp_q <= ctl_byte;
        end else begin
          cmd_valid_q <= 1'b1;
          cmd_byte_q <= rx_byte_q;
        end
      end
      // Reply byte outranks a pending acknowledge
      if (is_cmd && allowed &&
          ((rx_byte_q == dcs_pkg::CMD_RD_STAT) || (rx_byte_q == dcs_pkg::CMD_RD_CTL))) begin
        resp_pend_q <= 1'b1;
      end else if (tx_take && resp_pend_q) begin
        resp_pend_q <= 1'b0;
      end
      // New event wins over the clear of the previous one
      if (bp_event && acken_q) begin
        ack_pend_q <= 1'b1;
      end else if (tx_take && !resp_pend_q) begin
        ack_pend_q <= 1'b0;
      end
    end
  end

endmodule : dcs_debugger_control_status

// ==== sim/dcs_checker.sv ====
/*
  Checker: port properties of the debugger control block.
  Assumes one clock domain; bound at the foot of this file.
*/
`timescale 1ns/1ps
module dcs_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Line and CPU side
  input wire logic DEBUG_LINE_OE,
  input wire logic BREAK_DECODE,
  input wire logic WATCH_HIT,
  input wire logic READ_PROTECT,
  input wire logic RESET_DONE,
  input wire logic BREAK_AS_NOP,
  input wire logic DEBUG_MODE,
  input wire logic DEVICE_RESET_REQ,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_BYTE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  nop_break_a: assert property (BREAK_AS_NOP && !WATCH_HIT && !DEBUG_MODE |-> BREAK_DECODE ##1 !DEBUG_MODE)
    else $error("break taken while breakpoints off");
  break_enter_a: assert property (BREAK_DECODE && !BREAK_AS_NOP || WATCH_HIT |=> DEBUG_MODE)
    else $error("debug mode not entered");
  reset_clear_a: assert property (DEVICE_RESET_REQ && RESET_DONE |=> !DEVICE_RESET_REQ)
    else $error("reset bit not cleared");
  reset_done_a: assert property ($fell(DEVICE_RESET_REQ) |-> $past(RESET_DONE))
    else $error("reset bit cleared early");
  start_bit_a: assert property ($rose(DEBUG_LINE_OE) |-> DEBUG_LINE_OE [*8])
    else $error("start bit too short");
  rx_tx_a: assert property (DEBUG_LINE_OE |-> !CMD_VALID)
    else $error("receive while sending");
  cmd_mode_a: assert property (CMD_VALID && CMD_BYTE inside {8'h06, 8'h07, 8'h09} |-> $past(DEBUG_MODE))
    else $error("command outside debug mode");
  cmd_protect_a: assert property (CMD_VALID && CMD_BYTE inside {8'h06, 8'h07, 8'h09} |-> !$past(READ_PROTECT))
    else $error("command under read protect");
endmodule : dcs_checker
bind dcs_debugger_control_status dcs_checker chk (.*);

// ==== sim/dcs_host_model.sv ====
/*
  Host model on the open-drain debug line: framed bytes out and in.
  Assumes a pull-up on the line; tasks are entered at a falling edge.
*/
`timescale 1ns/1ps
module dcs_host_model (
  // Clock and line
  input wire logic clk,
  input wire logic line,
  output logic host_low = 1'b0
);
  // Start low, data LSB first, stop high; only after a reply ended
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_low <= !f[i];
      repeat (dcs_pkg::BIT_CYCLES) @(negedge clk);
    end
  endtask : send
  // Bounded wait for a start bit, mid-bit sampling
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    b = 8'h00;
    n = 0;
    while (line && n < 3 * dcs_pkg::BIT_CYCLES) begin
      @(negedge clk);
      n++;
    end
    ok = !line;
    if (ok) begin
      repeat (dcs_pkg::HALF_CYCLES) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (dcs_pkg::BIT_CYCLES) @(negedge clk);
        b[i] = line;
      end
      repeat (dcs_pkg::BIT_CYCLES) @(negedge clk);
      ok = line;
      // Let the sender leave its stop bit
      repeat (dcs_pkg::BIT_CYCLES) @(negedge clk);
    end
  endtask : recv
endmodule : dcs_host_model

// ==== sim/dcs_debugger_control_status_bench.sv ====
/*
  Bench for the debugger control block: host model, random CPU state.
  Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
module dcs_debugger_control_status_bench;
  logic clk = 1'b0, arst_n = 1'b0, op_break = 1'b0, watch = 1'b0;
  logic halt = 1'b0, rp = 1'b0, done = 1'b0, ok;
  logic line_oe, line_out, host_low, as_nop, in_debug, rst_req, cmd_v;
  logic [7:0] cmd_b, got, c;
  logic [7:0] rc [3] = '{8'h06, 8'h07, 8'h09};
  int bad_count = 0, n_checks = 0, cyc = 0, n_fwd = 0;
  wire line = !(line_oe || host_low);
  dcs_debugger_control_status dut (.CORE_CLK(clk), .ARST_N(arst_n), .DEBUG_LINE_IN(line),
    .DEBUG_LINE_OUT(line_out), .DEBUG_LINE_OE(line_oe), .BREAK_DECODE(op_break), .WATCH_HIT(watch),
    .HALT_MODE(halt), .READ_PROTECT(rp), .RESET_DONE(done), .BREAK_AS_NOP(as_nop),
    .DEBUG_MODE(in_debug), .DEVICE_RESET_REQ(rst_req), .CMD_VALID(cmd_v), .CMD_BYTE(cmd_b));
  dcs_host_model host (.clk(clk), .line(line), .host_low(host_low));
  initial forever #10 clk = ~clk;
  // Pulse counter, so the bench never writes a flag the clock side also writes
  always @(posedge clk) begin
    if (cmd_v) begin
      n_fwd <= n_fwd + 1;
    end
  end
  // Hang guard, about 20 bytes of traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------
  // Checks and expectations
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
    end
  endtask : chk
  function automatic logic [7:0] stat_exp(input logic d, input logic h, input logic r);
    return {d, h, r, 5'h00};
  endfunction : stat_exp
  function automatic logic allowed(input logic [7:0] k, input logic d, input logic r);
    return (k inside {8'h00, 8'h02, 8'h04, 8'h05}) || d && !(r && k inside {8'h06, 8'h07, 8'h09});
  endfunction : allowed
  task automatic rd(input logic [7:0] k, input logic [7:0] e);
    host.send(k);
    host.recv(got, ok);
    chk(ok, 1'b1, "reply framing");
    chk(got, e, "reply byte");
  endtask : rd
  task automatic fwd(input logic [7:0] k, input logic e);
    int n0;
    n0 = n_fwd;
    host.send(k);
    repeat (4) @(negedge clk);
    chk(8'(n_fwd - n0), {7'h00, e}, "forwarding");
    if (e) begin
      chk(cmd_b, k, "command byte");
    end
  endtask : fwd
  task automatic pulse_break(input logic en);
    op_break = 1'b1;
    #1;
    chk(as_nop, !en, "nop flag");
    @(negedge clk);
    op_break = 1'b0;
  endtask : pulse_break
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hfc63));
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk(line_out, 1'b0, "open drain data");
    chk(in_debug, 1'b0, "reset debug mode");
    rd(8'h02, 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset values done");
    pulse_break(1'b0);
    chk(in_debug, 1'b0, "break as nop");
    host.recv(got, ok);
    chk(ok, 1'b0, "no ack");
    c = rc[$urandom % 3];
    fwd(8'h00, allowed(8'h00, 1'b0, 1'b0));
    fwd(c, allowed(c, 1'b0, 1'b0));
    $display("test normal mode done");
    host.send(8'h04);
    host.send(8'h60);
    pulse_break(1'b1);
    chk(in_debug, 1'b1, "break entry");
    host.recv(got, ok);
    chk(ok, 1'b1, "ack framing");
    chk(got, 8'hff, "ack char");
    halt = 1'($urandom);
    rp = 1'($urandom);
    rd(8'h02, stat_exp(1'b1, halt, rp));
    rp = 1'b1;
    fwd(c, allowed(c, 1'b1, 1'b1));
    rp = 1'b0;
    fwd(c, allowed(c, 1'b1, 1'b0));
    $display("test debug mode done");
    rp = 1'($urandom);
    host.send(8'h04);
    host.send(8'h01);
    repeat ($urandom % 50 + 1) @(negedge clk);
    chk(rst_req, 1'b1, "reset held");
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    chk(rst_req, 1'b0, "reset cleared");
    rd(8'h05, {rp, 7'h00});
    watch = 1'b1;
    @(negedge clk);
    watch = 1'b0;
    chk(in_debug, 1'b1, "watch entry");
    host.recv(got, ok);
    chk(ok, 1'b0, "ack disabled");
    $display("test reset and watch done");
    end_sim();
  end
endmodule : dcs_debugger_control_status_bench
